// ===== verilog/lar_top.sv
// Light sensor alert reporting and full-scale range selection with AXI4-Lite registers
`timescale 1ns/100ps

// Behaviour
// (R1) Alert pin is open-drain, wired sharing
// (R2) Writable polarity sets alert active level
// (R3) Latch bit: 0 hysteresis, 1 latched window
// (R4) Hysteresis alert: on above high, off below low
// (R5) Hysteresis high flag set above, cleared below
// (R6) Hysteresis low flag set below, cleared above
// (R7) Latched alert holds until flags register read
// (R8) Latched flags clear only on flags read
// (R9) Limit comparisons form the fault events
// (R10) Act only after configured consecutive fault count
// (R11) Function 1: 1us pulse every conversion
// (R12) Function 3: pulse every fourth conversion
// (R13) Flags keep updating under conversion functions
// (R14) Range field 0xC selects automatic range
// (R15) Low reading: lower range one or two
// (R16) High reading: raise range one step
// (R17) Overrange: abort, unreported, step up, retry
// (R18) Manual range 0..8 fixes the range
// (R19) Limit code is mantissa shifted 8 plus exponent
// (R20) Measurement code is mantissa shifted by exponent
// (R21) Non-fault measurement restarts fault run
// (R22) Host reads flags to release latched alert
module lar_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Converter link
    input  wire logic        conv_clk,
    input  wire logic        conv_done,
    input  wire logic        conv_overrange,
    input  wire logic [3:0]  conv_exponent,
    input  wire logic [19:0] conv_mantissa,
    output logic [3:0]       conv_range,
    output logic             conv_retry,
    // Open-drain alert pin
    input  wire logic        alert_in,
    output logic             alert_out,
    output logic             alert_oe
);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [lar_pkg::LAR_CODE_W-1:0] meas_code(input logic [3:0]  ex,
                                                                 input logic [19:0] man);
        return lar_pkg::LAR_CODE_W'(man) << ex; // (R20)
    endfunction

    function automatic logic [lar_pkg::LAR_CODE_W-1:0] limit_code(input lar_pkg::lar_thresh_t t);
        return lar_pkg::LAR_CODE_W'(t.result) << (lar_pkg::LAR_THR_SHIFT + 5'(t.exponent)); // (R19)
    endfunction

    lar_pkg::lar_cfg_t    cfg;
    lar_pkg::lar_thresh_t thresh_h;
    lar_pkg::lar_thresh_t thresh_l;
    logic                 flag_h;
    logic                 flag_l;
    logic [23:0]          last_result;
    logic                 aw_held;
    logic                 w_held;
    logic [7:0]           aw_addr;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    lar_pkg::lar_meas_t   meas_s1;
    lar_pkg::lar_meas_t   meas_s2;
    logic                 cclk_s1;
    logic                 cclk_s2;
    logic                 cclk_s3;
    logic [3:0]           run_h;
    logic [3:0]           run_l;
    logic                 thr_alert;
    logic [1:0]           fifo_cnt;
    logic [7:0]           pulse_cnt;
    logic [3:0]           auto_range;
    logic                 wr_go;
    logic                 rd_go;
    logic                 flags_read;
    logic                 take;
    logic                 is_auto;
    logic                 abort_meas;
    logic                 report;
    logic                 fault_h;
    logic                 fault_l;
    logic [3:0]           need;
    logic                 qual_h;
    logic                 qual_l;
    logic [lar_pkg::LAR_CODE_W-1:0] code;
    logic                 alert_active;
    logic [3:0]           next_range;

    assign wr_go      = aw_held && w_held && !s_axi_bvalid;
    assign rd_go      = s_axi_arvalid && s_axi_arready;
    assign flags_read = rd_go && (s_axi_araddr == lar_pkg::LAR_ADDR_FLAGS);
    assign take       = cclk_s2 && !cclk_s3 && meas_s2.done;
    assign is_auto    = (cfg.range == lar_pkg::LAR_RANGE_AUTO); // (R14)
    // Abort only below the top range; at the top a saturated reading is still reported
    assign abort_meas = take && is_auto && meas_s2.overrange
                        && (auto_range != lar_pkg::LAR_RANGE_MAX); // (R17)
    assign report     = take && !abort_meas;
    assign code       = meas_code(meas_s2.exponent, meas_s2.mantissa);
    assign fault_h    = code > limit_code(thresh_h); // (R9)
    assign fault_l    = code < limit_code(thresh_l); // (R9)
    assign need       = 4'h1 << cfg.fault_count;
    assign qual_h     = report && fault_h && (run_h + 4'h1 >= need); // (R10)
    assign qual_l     = report && fault_l && (run_l + 4'h1 >= need); // (R10)

    // Next automatic range from the mantissa's position in full scale
    always_comb begin
        next_range = auto_range;
        if (abort_meas) begin
            next_range = auto_range + 4'h1; // (R17)
        end else if (meas_s2.mantissa[19:18] == 2'b11) begin
            if (auto_range != lar_pkg::LAR_RANGE_MAX) begin
                next_range = auto_range + 4'h1; // (R16)
            end
        end else if (meas_s2.mantissa[19:16] == 4'h0) begin
            if (auto_range > 4'h1) begin
                next_range = auto_range - 4'h2; // (R15)
            end else begin
                next_range = lar_pkg::LAR_RANGE_MIN; // (R15)
            end
        end else if (meas_s2.mantissa[19:18] == 2'b00) begin
            if (auto_range != lar_pkg::LAR_RANGE_MIN) begin
                next_range = auto_range - 4'h1; // (R15)
            end
        end
    end

    // Alert source by function; other encodings leave the pin inactive
    always_comb begin
        case (cfg.alert_func)
            lar_pkg::LAR_FUNC_FAULT: alert_active = thr_alert;
            lar_pkg::LAR_FUNC_CONV:  alert_active = (pulse_cnt != 8'h00); // (R11)
            lar_pkg::LAR_FUNC_FIFO:  alert_active = (pulse_cnt != 8'h00); // (R12)
            default:                 alert_active = 1'b0;
        endcase
    end

    // Link inputs, two stages before any use
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meas_s1 <= '0;
            meas_s2 <= '0;
            cclk_s1 <= 1'b0;
            cclk_s2 <= 1'b0;
            cclk_s3 <= 1'b0;
        end else begin
            meas_s1 <= {conv_done, conv_overrange, conv_exponent, conv_mantissa};
            meas_s2 <= meas_s1;
            cclk_s1 <= conv_clk;
            cclk_s2 <= cclk_s1;
            cclk_s3 <= cclk_s2;
        end
    end

    // AXI write channel
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= lar_pkg::LAR_RESP_OKAY;
        end else begin
            if (!aw_held && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (!w_held && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (aw_addr)
                    lar_pkg::LAR_ADDR_CONFIG,
                    lar_pkg::LAR_ADDR_THRESH_H,
                    lar_pkg::LAR_ADDR_THRESH_L,
                    lar_pkg::LAR_ADDR_FLAGS,
                    lar_pkg::LAR_ADDR_RESULT: s_axi_bresp <= lar_pkg::LAR_RESP_OKAY;
                    default:                  s_axi_bresp <= lar_pkg::LAR_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Writable registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg      <= lar_pkg::LAR_CFG_RST;
            thresh_h <= lar_pkg::LAR_THRESH_H_RST;
            thresh_l <= lar_pkg::LAR_THRESH_L_RST;
        end else if (wr_go) begin
            case (aw_addr)
                lar_pkg::LAR_ADDR_CONFIG:
                    cfg <= lar_pkg::LAR_CFG_W'(merge_bytes(32'(cfg), w_data, w_strb)); // (R2) (R3)
                lar_pkg::LAR_ADDR_THRESH_H:
                    thresh_h <= lar_pkg::LAR_THRESH_W'(merge_bytes(32'(thresh_h), w_data, w_strb));
                lar_pkg::LAR_ADDR_THRESH_L:
                    thresh_l <= lar_pkg::LAR_THRESH_W'(merge_bytes(32'(thresh_l), w_data, w_strb));
                default: ;
            endcase
        end
    end

    // AXI read channel
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= lar_pkg::LAR_RESP_OKAY;
        end else begin
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= lar_pkg::LAR_RESP_OKAY;
                s_axi_rdata   <= '0;
                case (s_axi_araddr)
                    lar_pkg::LAR_ADDR_CONFIG:   s_axi_rdata <= 32'(cfg);
                    lar_pkg::LAR_ADDR_THRESH_H: s_axi_rdata <= 32'(thresh_h);
                    lar_pkg::LAR_ADDR_THRESH_L: s_axi_rdata <= 32'(thresh_l);
                    lar_pkg::LAR_ADDR_FLAGS: begin
                        s_axi_rdata[lar_pkg::LAR_FLAG_H_BIT] <= flag_h;
                        s_axi_rdata[lar_pkg::LAR_FLAG_L_BIT] <= flag_l;
                        s_axi_rdata[lar_pkg::LAR_FLAG_RNG_LSB +: 4] <= conv_range;
                    end
                    lar_pkg::LAR_ADDR_RESULT:   s_axi_rdata <= 32'(last_result);
                    default:                    s_axi_rresp <= lar_pkg::LAR_RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Consecutive fault runs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            run_h <= '0;
            run_l <= '0;
        end else if (report) begin
            if (!fault_h) begin
                run_h <= '0; // (R21)
            end else if (run_h < need) begin
                run_h <= run_h + 4'h1; // (R10)
            end
            if (!fault_l) begin
                run_l <= '0; // (R21)
            end else if (run_l < need) begin
                run_l <= run_l + 4'h1; // (R10)
            end
        end
    end

    // Flags and threshold alert; a new event wins over a clearing read
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flag_h    <= 1'b0;
            flag_l    <= 1'b0;
            thr_alert <= 1'b0;
        end else if (!cfg.latch) begin // (R3)
            if (qual_h) begin
                flag_h    <= 1'b1; // (R5) (R13)
                flag_l    <= 1'b0; // (R6)
                thr_alert <= 1'b1; // (R4)
            end else if (qual_l) begin
                flag_h    <= 1'b0; // (R5)
                flag_l    <= 1'b1; // (R6) (R13)
                thr_alert <= 1'b0; // (R4)
            end
        end else begin
            if (qual_h) begin
                flag_h <= 1'b1; // (R8) (R13)
            end else if (flags_read) begin
                flag_h <= 1'b0; // (R8) (R22)
            end
            if (qual_l) begin
                flag_l <= 1'b1; // (R8) (R13)
            end else if (flags_read) begin
                flag_l <= 1'b0; // (R8) (R22)
            end
            if (qual_h || qual_l) begin
                thr_alert <= 1'b1; // (R7)
            end else if (flags_read) begin
                thr_alert <= 1'b0; // (R7)
            end
        end
    end

    // Conversion pulses and the last reported result
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fifo_cnt    <= '0;
            pulse_cnt   <= '0;
            last_result <= '0;
        end else begin
            if (report) begin
                fifo_cnt    <= fifo_cnt + 2'h1;
                last_result <= {meas_s2.exponent, meas_s2.mantissa};
            end
            if (report && (cfg.alert_func == lar_pkg::LAR_FUNC_CONV)) begin
                pulse_cnt <= lar_pkg::LAR_PULSE_CYCLES; // (R11)
            end else if (report && (cfg.alert_func == lar_pkg::LAR_FUNC_FIFO)
                         && (fifo_cnt == lar_pkg::LAR_FIFO_LAST)) begin
                pulse_cnt <= lar_pkg::LAR_PULSE_CYCLES; // (R12)
            end else if (pulse_cnt != 8'h00) begin
                pulse_cnt <= pulse_cnt - 8'h01;
            end
        end
    end

    // Range selection toward the converter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            auto_range <= lar_pkg::LAR_RANGE_MAX;
            conv_range <= lar_pkg::LAR_RANGE_MAX;
            conv_retry <= 1'b0;
        end else begin
            conv_retry <= abort_meas; // (R17)
            if (is_auto) begin
                if (take) begin
                    auto_range <= next_range; // (R15) (R16)
                    conv_range <= next_range; // (R14)
                end else begin
                    conv_range <= auto_range;
                end
            end else if (cfg.range <= lar_pkg::LAR_RANGE_MAX) begin
                conv_range <= cfg.range; // (R18)
                auto_range <= cfg.range;
            end else begin
                conv_range <= lar_pkg::LAR_RANGE_MAX;
                auto_range <= lar_pkg::LAR_RANGE_MAX;
            end
        end
    end

    // Open-drain pin: only ever pulls low
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            alert_out <= 1'b0;
            alert_oe  <= 1'b0;
        end else begin
            alert_out <= 1'b0; // (R1)
            alert_oe  <= cfg.alert_polarity ? !alert_active : alert_active; // (R1) (R2)
        end
    end

endmodule // lar_top

// ===== verilog/lar_pkg.sv
// Package: register map, field layouts and timing for the light alert and autorange block
package lar_pkg;

    // Register byte addresses
    localparam logic [7:0] LAR_ADDR_CONFIG   = 8'h00;
    localparam logic [7:0] LAR_ADDR_THRESH_H = 8'h04;
    localparam logic [7:0] LAR_ADDR_THRESH_L = 8'h08;
    localparam logic [7:0] LAR_ADDR_FLAGS    = 8'h0C;
    localparam logic [7:0] LAR_ADDR_RESULT   = 8'h10;
    localparam int         LAR_ADDR_W        = 8;

    // Configuration word
    typedef struct packed {
        logic [1:0] fault_count;
        logic [1:0] alert_func;
        logic       alert_polarity;
        logic       latch;
        logic [3:0] range;
    } lar_cfg_t;

    // Threshold word
    typedef struct packed {
        logic [3:0]  exponent;
        logic [11:0] result;
    } lar_thresh_t;

    // Measurement as presented by the converter
    typedef struct packed {
        logic        done;
        logic        overrange;
        logic [3:0]  exponent;
        logic [19:0] mantissa;
    } lar_meas_t;

    localparam int LAR_CFG_W    = 10;
    localparam int LAR_THRESH_W = 16;
    localparam int LAR_CODE_W   = 36;

    localparam lar_cfg_t    LAR_CFG_RST      = 10'h00C;
    localparam lar_thresh_t LAR_THRESH_H_RST = 16'hFFFF;
    localparam lar_thresh_t LAR_THRESH_L_RST = 16'h0000;

    // Field encodings
    localparam logic [3:0] LAR_RANGE_AUTO = 4'hC;
    localparam logic [3:0] LAR_RANGE_MAX  = 4'h8;
    localparam logic [3:0] LAR_RANGE_MIN  = 4'h0;
    localparam logic [1:0] LAR_FUNC_FAULT = 2'h0;
    localparam logic [1:0] LAR_FUNC_CONV  = 2'h1;
    localparam logic [1:0] LAR_FUNC_FIFO  = 2'h3;
    localparam logic [4:0] LAR_THR_SHIFT  = 5'h08;
    localparam logic [1:0] LAR_FIFO_LAST  = 2'h3;

    // Flag register bit positions
    localparam int LAR_FLAG_H_BIT   = 0;
    localparam int LAR_FLAG_L_BIT   = 1;
    localparam int LAR_FLAG_RNG_LSB = 4;

    // AXI responses
    localparam logic [1:0] LAR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] LAR_RESP_SLVERR = 2'h2;

    // Alert pulse width
    localparam int         LAR_CLK_PERIOD_NS = 4;
    localparam int         LAR_PULSE_NS      = 1000;
    localparam logic [7:0] LAR_PULSE_CYCLES  = 8'(LAR_PULSE_NS / LAR_CLK_PERIOD_NS);

endpackage

// ===== verification/lar_top_sva.sv
// Port checks for the light alert and autorange block
`timescale 1ns/100ps
module lar_top_sva (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        conv_done,
    input wire logic        conv_overrange,
    input wire logic [3:0]  conv_range,
    input wire logic        conv_retry,
    input wire logic        alert_out
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    alert_drain_a: assert property (alert_out == 1'b0)
        else $error("alert driven high");
    range_legal_a: assert property (conv_range <= lar_pkg::LAR_RANGE_MAX)
        else $error("range too high");
    retry_pulse_a: assert property (conv_retry |=> !conv_retry)
        else $error("retry too long");
    retry_step_a: assert property (conv_retry |-> conv_range == $past(conv_range) + 4'h1)
        else $error("retry without step");
    retry_cause_a: assert property (conv_retry |-> $past(conv_overrange, 2) && $past(conv_done, 2))
        else $error("retry without overrange");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("bresp dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("rdata dropped");
    read_single_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read overlap");
endmodule // lar_top_sva

bind lar_top lar_top_sva lar_top_sva_i (.sys_clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .conv_done, .conv_overrange,
    .conv_range, .conv_retry, .alert_out);

// ===== verification/lar_conv_model.sv
// Converter model: frames one reading around a link clock edge
`timescale 1ns/100ps
module lar_conv_model (
    output logic        conv_clk,
    output logic        conv_done,
    output logic        conv_overrange,
    output logic [3:0]  conv_exponent,
    output logic [19:0] conv_mantissa
);
    initial {conv_clk, conv_done, conv_overrange, conv_exponent, conv_mantissa} = 27'h0;

    // Link clock stands still between frames; released lines show the inverse
    task automatic send(input logic [3:0] e, input logic [19:0] m, input logic o);
        #1;
        conv_exponent = e;
        conv_mantissa = m;
        conv_overrange = o;
        conv_done = 1'b1;
        #80;
        conv_clk = 1'b1;
        #80;
        conv_clk = 1'b0;
        conv_done = 1'b0;
        conv_exponent = ~e;
        conv_mantissa = ~m;
        conv_overrange = ~o;
        #80;
    endtask
endmodule // lar_conv_model

// ===== verification/lar_top_tb_top.sv
// Testbench for the light alert and autorange block
`timescale 1ns/100ps
module lar_top_tb_top;
    localparam CFG = lar_pkg::LAR_ADDR_CONFIG;
    localparam THH = lar_pkg::LAR_ADDR_THRESH_H;
    localparam THL = lar_pkg::LAR_ADDR_THRESH_L;
    localparam FLG = lar_pkg::LAR_ADDR_FLAGS;
    localparam RES = lar_pkg::LAR_ADDR_RESULT;
    localparam OK  = lar_pkg::LAR_RESP_OKAY;
    localparam ERR = lar_pkg::LAR_RESP_SLVERR;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic        conv_clk, conv_done, conv_overrange, conv_retry, alert_out, alert_oe;
    logic [3:0]  conv_exponent, conv_range;
    logic [19:0] conv_mantissa;
    wire         alert_in = !alert_oe;
    int          bad_count = 0, n_compared = 0, n_conv = 0, retry_cnt = 0, run = 0, width = 0;
    // Hysteresis walk: exponent bit, mantissa, flags word, pin level
    logic [0:9]  t_x = 10'b0000000111;
    logic [19:0] t_m [10] = '{20'h02000, 20'h00800, 20'h02000, 20'h02000, 20'h00800,
                              20'h00050, 20'h00050, 20'h00100, 20'h00101, 20'h00101};
    logic [7:0]  t_f [10] = '{8'h30, 8'h30, 8'h30, 8'h31, 8'h31, 8'h31, 8'h32, 8'h32, 8'h32, 8'h31};
    logic [0:9]  t_p = 10'b1110001110;

    lar_top lar_top_i (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_clk, .conv_done, .conv_overrange,
        .conv_exponent, .conv_mantissa, .conv_range, .conv_retry, .alert_in, .alert_out,
        .alert_oe);
    lar_conv_model lar_conv_model_i (.conv_clk, .conv_done, .conv_overrange, .conv_exponent,
        .conv_mantissa);

    initial forever #2 sys_clk = ~sys_clk;

    // Retry count, last pull-down width
    always @(posedge sys_clk) begin
        if (conv_retry === 1'b1) retry_cnt <= retry_cnt + 1;
        if (alert_oe === 1'b1) run <= run + 1;
        else begin
            if (run != 0) width <= run;
            run <= 0;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("mismatches %0d of %0d compares", bad_count, n_compared);
        if (bad_count == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
        s_axi_bready <= 1'b1;
        @(posedge sys_clk);
        check(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
        s_axi_rready <= 1'b1;
        @(posedge sys_clk);
        check(s_axi_rdata, ed);
        check(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
    endtask

    // Aborted readings are not reported or counted
    task automatic conv(input logic [3:0] e, input logic [19:0] m, input logic o);
        lar_conv_model_i.send(e, m, o);
        if (!o) n_conv++;
    endtask

    initial begin
        #200000;
        bad_count++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check(32'(conv_range), 32'h8);
        axi_rd(CFG, 32'h0000000C, OK);
        axi_rd(THH, 32'h0000FFFF, OK);
        axi_rd(THL, 32'h00000000, OK);
        axi_rd(8'h14, 32'h0, ERR);
        axi_wr(8'h14, 32'h5, ERR);
        for (int i = 1; i <= 5; i++) begin
            conv(4'h0, 20'h00100, 1'b0);
            check(32'(conv_range), (i < 4) ? 32'(8 - 2 * i) : 32'h0);
        end
        conv(4'h0, 20'hC0000, 1'b0);
        check(32'(conv_range), 32'h1);
        conv(4'h1, 20'h20000, 1'b0);
        check(32'(conv_range), 32'h0);
        conv(4'h0, 20'hC0000, 1'b0);
        conv(4'h1, 20'hFFFFF, 1'b1);
        check(32'(conv_range), 32'h2);
        check(32'(retry_cnt), 32'h1);
        axi_rd(RES, 32'h000C0000, OK);
        axi_wr(CFG, 32'h003, OK);
        conv(4'h3, 20'h80000, 1'b0);
        check(32'(conv_range), 32'h3);
        axi_rd(RES, 32'h00380000, OK);
        axi_rd(FLG, 32'h30, OK);
        axi_wr(THH, 32'h0010, OK);
        axi_wr(THL, 32'h0001, OK);
        axi_wr(CFG, 32'h103, OK);
        for (int i = 0; i < 10; i++) begin
            if (i == 7) axi_wr(THH, 32'h1001, OK);
            conv({3'h0, t_x[i]}, t_m[i], 1'b0);
            axi_rd(FLG, 32'(t_f[i]), OK);
            check(32'(alert_in), 32'(t_p[i]));
        end
        axi_wr(CFG, 32'h013, OK);
        axi_rd(FLG, 32'h31, OK);
        axi_rd(FLG, 32'h30, OK);
        check(32'(alert_in), 32'h1);
        conv(4'h0, 20'h00050, 1'b0);
        conv(4'h0, 20'h00180, 1'b0);
        check(32'(alert_in), 32'h0);
        axi_rd(FLG, 32'h32, OK);
        axi_rd(FLG, 32'h30, OK);
        check(32'(alert_in), 32'h1);
        axi_wr(CFG, 32'h033, OK);
        repeat (3) @(posedge sys_clk);
        check(32'(alert_in), 32'h0);
        conv(4'h0, 20'h02000, 1'b0);
        check(32'(alert_in), 32'h1);
        axi_rd(FLG, 32'h31, OK);
        axi_wr(CFG, 32'h043, OK);
        conv(4'h0, 20'h02000, 1'b0);
        check(32'(alert_in), 32'h0);
        repeat (300) @(posedge sys_clk);
        check(32'(width), 32'(lar_pkg::LAR_PULSE_CYCLES));
        axi_rd(FLG, 32'h31, OK);
        axi_wr(CFG, 32'h0C3, OK);
        repeat (4) begin
            conv(4'h0, 20'h00180, 1'b0);
            check(32'(alert_in), (n_conv % 4 == 0) ? 32'h0 : 32'h1);
            repeat (300) @(posedge sys_clk);
        end
        test_done();
    end
endmodule // lar_top_tb_top
